// *** hdasp_regs.vh ***
// Constants for the half-duplex asynchronous serial port.
// Assumes inclusion by bare name from the design files.
`ifndef HDASP_REGS_VH
`define HDASP_REGS_VH
// Character layout
`define HDASP_DATA_BITS     4'd9
`define HDASP_LAST_DATA     4'd8
`define HDASP_STATES_PER_BIT 3'd7
// Majority sample phases within a bit
`define HDASP_SAMPLE_A      3'd3
`define HDASP_SAMPLE_B      3'd4
`define HDASP_SAMPLE_C      3'd5
// Control byte field positions
`define HDASP_CR_RX_READY_FLAG      7
`define HDASP_CR_TXEMPTY    6
`define HDASP_CR_RXIEN      5
`define HDASP_CR_TXIEN      4
`define HDASP_CR_BAUD_HI    3
`define HDASP_CR_BAUD_LO    1
`define HDASP_CR_NINTH      0
// Divisors of the internal clock, per baud select code
`define HDASP_DIV0          13'd6656
`define HDASP_DIV1          13'd3328
`define HDASP_DIV2          13'd1664
`define HDASP_DIV3          13'd832
`define HDASP_DIV4          13'd416
`define HDASP_DIV5          13'd256
`define HDASP_DIV6          13'd208
`define HDASP_DIV7          13'd0
`endif

// *** hdasp_baud_div.v ***
// Baud divider: one-cycle tick at eight times the bit rate.
// Assumes divisor table counts internal clock cycles per bit.
`timescale 1ns/100ps
`include "hdasp_regs.vh"
module hdasp_baud_div #(
   parameter CNT_W = 13
) (
   // Clock and reset
   input  wire             clk_sys,
   input  wire             rst_n,
   // Control
   input  wire [2:0]       baud_select,
   input  wire             run,
   // Tick out
   output reg              tick_r
);
   reg  [CNT_W-1:0] cnt_r;
   wire [CNT_W-1:0] period;

   function [CNT_W-1:0] div_of;
      input [2:0] sel;
      begin
         case (sel)
            3'h0: div_of = `HDASP_DIV0;
            3'h1: div_of = `HDASP_DIV1;
            3'h2: div_of = `HDASP_DIV2;
            3'h3: div_of = `HDASP_DIV3;
            3'h4: div_of = `HDASP_DIV4;
            3'h5: div_of = `HDASP_DIV5;
            3'h6: div_of = `HDASP_DIV6;
            default: div_of = `HDASP_DIV7;
         endcase
      end
   endfunction

   // Eighth of the bit period; select takes effect at once
   assign period = div_of(baud_select) >> 3;

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r  <= {CNT_W{1'b0}};
         tick_r <= 1'b0;
      end else if (!run || period == {CNT_W{1'b0}}) begin
         cnt_r  <= {CNT_W{1'b0}};
         tick_r <= 1'b0;
      end else if (cnt_r >= period - {{(CNT_W-1){1'b0}}, 1'b1}) begin
         cnt_r  <= {CNT_W{1'b0}};
         tick_r <= 1'b1;
      end else begin
         cnt_r  <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
         tick_r <= 1'b0;
      end
   end
endmodule

// *** hdasp_rx_vote.v ***
// Three-sample majority vote over one bit period.
// Assumes phase counts 0..7 on the state ticks of the bit.
`timescale 1ns/100ps
`include "hdasp_regs.vh"
module hdasp_rx_vote (
   // Clock and reset
   input  wire       clk_sys,
   input  wire       rst_n,
   // Sampling
   input  wire       tick,
   input  wire [2:0] phase,
   input  wire       rx_in,
   // Decided level
   output wire       bit_level
);
   reg [2:0] smp_r;

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         smp_r <= 3'h7;
      end else if (tick) begin
         if (phase == `HDASP_SAMPLE_A) smp_r[0] <= rx_in;
         if (phase == `HDASP_SAMPLE_B) smp_r[1] <= rx_in;
         if (phase == `HDASP_SAMPLE_C) smp_r[2] <= rx_in;
      end
   end

   // Two of three decides
   assign bit_level = (smp_r[0] & smp_r[1]) | (smp_r[0] & smp_r[2])
                    | (smp_r[1] & smp_r[2]);
endmodule

// *** hdasp_top.v ***
// Half-duplex asynchronous serial port, device side.
// Assumes control/data accesses arrive as one-cycle strobes on clk_sys.
`timescale 1ns/100ps
`include "hdasp_regs.vh"
module hdasp_top (
   // Clock and reset
   input  wire       clk_sys,
   input  wire       rstn,
   // Data register access
   input  wire       data_wr,
   input  wire [7:0] data_wdata,
   output reg  [7:0] rx_data_r,
   // Control register access
   input  wire       ctrl_wr,
   input  wire [7:0] ctrl_wdata,
   output wire [7:0] ctrl_rdata,
   // Port pins
   input  wire       rx_pin,
   input  wire       port_tx_value,
   output wire       tx_pin,
   output wire       rx_port_value,
   output wire       tx_output_select,
   // Interrupt requests
   output wire       tx_irq,
   output wire       rx_irq
);
   localparam TX_IDLE  = 2'd0;
   localparam TX_START = 2'd1;
   localparam TX_DATA  = 2'd2;
   localparam TX_STOP  = 2'd3;
   localparam RX_IDLE  = 2'd0;
   localparam RX_START = 2'd1;
   localparam RX_DATA  = 2'd2;
   localparam RX_STOP  = 2'd3;

   reg        rst_s1_r;
   reg        rst_n_r;
   reg        tx_empty_flag_r;
   reg        rx_ready_flag_r;
   reg        rx_ien_r;
   reg        tx_ien_r;
   reg  [2:0] baud_select_r;
   reg        ninth_bit_r;
   reg  [1:0] tx_st_r;
   reg  [2:0] tx_ph_r;
   reg  [3:0] tx_cnt_r;
   reg  [8:0] tx_sh_r;
   reg        tx_bit_r;
   reg  [1:0] rx_st_r;
   reg  [2:0] rx_ph_r;
   reg  [3:0] rx_cnt_r;
   reg  [8:0] rx_sh_r;
   reg        rx_prev_r;
   wire       tick;
   wire       bit_level;
   wire       tx_done;
   wire       rx_done;
   wire       tx_bit_end;
   wire       rx_bit_end;

   // Reset release through two flops
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rst_s1_r <= 1'b0;
         rst_n_r  <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r  <= rst_s1_r;
      end
   end

   // Divider runs on the system clock, live in wait state
   hdasp_baud_div #(
      .CNT_W       (13)
   ) u_div (
      .clk_sys     (clk_sys),
      .rst_n       (rst_n_r),
      .baud_select (baud_select_r),
      .run         (1'b1),
      .tick_r      (tick)
   );

   hdasp_rx_vote u_vote (
      .clk_sys     (clk_sys),
      .rst_n       (rst_n_r),
      .tick        (tick),
      .phase       (rx_ph_r),
      .rx_in       (rx_pin),
      .bit_level   (bit_level)
   );

   assign tx_bit_end = tick && tx_ph_r == `HDASP_STATES_PER_BIT;
   assign rx_bit_end = tick && rx_ph_r == `HDASP_STATES_PER_BIT;
   assign tx_done    = tx_st_r == TX_STOP && tx_bit_end;
   assign rx_done    = rx_st_r == RX_STOP && rx_bit_end && !data_wr;

   // Transmitter
   always @(posedge clk_sys or negedge rst_n_r) begin
      if (!rst_n_r) begin
         tx_st_r  <= TX_IDLE;
         tx_ph_r  <= 3'h0;
         tx_cnt_r <= 4'h0;
         tx_sh_r  <= 9'h1ff;
         tx_bit_r <= 1'b1;
      end else if (data_wr) begin
         tx_st_r  <= TX_START;
         tx_ph_r  <= 3'h0;
         tx_cnt_r <= 4'h0;
         tx_sh_r  <= {ninth_bit_r, data_wdata};
         tx_bit_r <= 1'b0;
      end else if (tick) begin
         tx_ph_r <= tx_ph_r + 3'h1;
         if (tx_bit_end) begin
            case (tx_st_r)
               TX_START: begin
                  tx_st_r  <= TX_DATA;
                  tx_bit_r <= tx_sh_r[0];
                  tx_sh_r  <= {1'b1, tx_sh_r[8:1]};
               end
               TX_DATA: begin
                  if (tx_cnt_r == `HDASP_LAST_DATA) begin
                     tx_st_r  <= TX_STOP;
                     tx_bit_r <= 1'b1;
                  end else begin
                     tx_cnt_r <= tx_cnt_r + 4'h1;
                     tx_bit_r <= tx_sh_r[0];
                     tx_sh_r  <= {1'b1, tx_sh_r[8:1]};
                  end
               end
               TX_STOP: begin
                  tx_st_r  <= TX_IDLE;
                  tx_bit_r <= 1'b1;
               end
               default: begin
                  tx_st_r  <= TX_IDLE;
                  tx_bit_r <= 1'b1;
               end
            endcase
         end
      end
   end

   assign tx_output_select = tx_st_r != TX_IDLE;
   // Inverted serial output, else the port register
   assign tx_pin = tx_output_select ? ~tx_bit_r : port_tx_value;
   assign rx_port_value = rx_pin;

   // Receiver
   always @(posedge clk_sys or negedge rst_n_r) begin
      if (!rst_n_r) begin
         rx_st_r   <= RX_IDLE;
         rx_ph_r   <= 3'h0;
         rx_cnt_r  <= 4'h0;
         rx_sh_r   <= 9'h000;
         rx_prev_r <= 1'b1;
      end else if (data_wr || tx_output_select) begin
         rx_st_r   <= RX_IDLE;
         rx_ph_r   <= 3'h0;
         rx_prev_r <= 1'b1;
      end else begin
         rx_prev_r <= rx_pin;
         case (rx_st_r)
            RX_IDLE: begin
               if (rx_prev_r && !rx_pin) begin
                  rx_st_r  <= RX_START;
                  rx_ph_r  <= 3'h0;
                  rx_cnt_r <= 4'h0;
               end
            end
            RX_START: begin
               if (tick) rx_ph_r <= rx_ph_r + 3'h1;
               if (rx_bit_end) rx_st_r <= RX_DATA;
            end
            RX_DATA: begin
               if (tick) rx_ph_r <= rx_ph_r + 3'h1;
               if (rx_bit_end) begin
                  rx_sh_r <= {bit_level, rx_sh_r[8:1]};
                  if (rx_cnt_r == `HDASP_LAST_DATA) rx_st_r <= RX_STOP;
                  else rx_cnt_r <= rx_cnt_r + 4'h1;
               end
            end
            RX_STOP: begin
               if (tick) rx_ph_r <= rx_ph_r + 3'h1;
               if (rx_bit_end) rx_st_r <= RX_IDLE;
            end
            default: rx_st_r <= RX_IDLE;
         endcase
      end
   end

   // Receive buffer, separate from the shift register
   always @(posedge clk_sys or negedge rst_n_r) begin
      if (!rst_n_r) rx_data_r <= 8'h00;
      else if (rx_done) rx_data_r <= rx_sh_r[7:0];
   end

   // Control register and flags; hardware set wins over clear
   always @(posedge clk_sys or negedge rst_n_r) begin
      if (!rst_n_r) begin
         tx_empty_flag_r <= 1'b0;
         rx_ready_flag_r <= 1'b0;
         rx_ien_r        <= 1'b0;
         tx_ien_r        <= 1'b0;
         baud_select_r   <= 3'h0;
         ninth_bit_r     <= 1'b0;
      end else begin
         if (ctrl_wr) begin
            rx_ien_r      <= ctrl_wdata[`HDASP_CR_RXIEN];
            tx_ien_r      <= ctrl_wdata[`HDASP_CR_TXIEN];
            baud_select_r <= ctrl_wdata[`HDASP_CR_BAUD_HI:`HDASP_CR_BAUD_LO];
         end
         if (rx_done) ninth_bit_r <= rx_sh_r[8];
         else if (ctrl_wr) ninth_bit_r <= ctrl_wdata[`HDASP_CR_NINTH];
         if (tx_done) tx_empty_flag_r <= 1'b1;
         else if (data_wr) tx_empty_flag_r <= 1'b0;
         else if (ctrl_wr) tx_empty_flag_r <= ctrl_wdata[`HDASP_CR_TXEMPTY];
         if (rx_done) rx_ready_flag_r <= 1'b1;
         else if (ctrl_wr) rx_ready_flag_r <= ctrl_wdata[`HDASP_CR_RX_READY_FLAG];
      end
   end

   assign ctrl_rdata = {rx_ready_flag_r, tx_empty_flag_r, rx_ien_r, tx_ien_r,
                        baud_select_r, ninth_bit_r};
   assign tx_irq = tx_empty_flag_r & tx_ien_r;
   assign rx_irq = rx_ready_flag_r & rx_ien_r;
endmodule

// *** hdasp_top_monitor.sv ***
// Port checker for the half-duplex serial port.
// Assumes it is bound onto hdasp_top and sees only its ports.
`timescale 1ns/100ps
module hdasp_top_monitor (
   // Clock and reset
   input logic       clk_sys,
   input logic       rstn,
   // Register side
   input logic       data_wr,
   input logic [7:0] data_wdata,
   input logic [7:0] rx_data_r,
   input logic       ctrl_wr,
   input logic [7:0] ctrl_wdata,
   input logic [7:0] ctrl_rdata,
   // Pins and requests
   input logic       rx_pin,
   input logic       port_tx_value,
   input logic       tx_pin,
   input logic       rx_port_value,
   input logic       tx_output_select,
   input logic       tx_irq,
   input logic       rx_irq
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   a_idle_port_pin: assert property (!tx_output_select |-> tx_pin == port_tx_value)
      else $error("tx pin differs from port value");
   a_rx_port_copy: assert property (rx_port_value == rx_pin)
      else $error("rx port value differs from pin");
   a_start_bit_out: assert property (data_wr |=> tx_output_select && tx_pin)
      else $error("no start bit after data write");
   a_tx_irq_level: assert property (tx_irq == (ctrl_rdata[6] && ctrl_rdata[4]))
      else $error("tx request wrong");
   a_rx_irq_level: assert property (rx_irq == (ctrl_rdata[7] && ctrl_rdata[5]))
      else $error("rx request wrong");
   a_stop_then_empty: assert property ($fell(tx_output_select) |-> ctrl_rdata[6] && !$past(tx_pin, 8))
      else $error("end of character wrong");
   a_write_clears_empty: assert property (data_wr && !tx_output_select |=> !ctrl_rdata[6])
      else $error("empty flag not cleared");
   a_ctrl_field_wr: assert property (ctrl_wr |=> ctrl_rdata[5:1] == $past(ctrl_wdata[5:1]))
      else $error("control field not taken");
   a_rx_buf_ready: assert property ($changed(rx_data_r) |-> ctrl_rdata[7])
      else $error("buffer changed without ready");
   cover property ($fell(tx_output_select));
   cover property ($rose(ctrl_rdata[7]));
   cover property (rx_irq);
endmodule
bind hdasp_top hdasp_top_monitor u_hdasp_top_monitor (.clk_sys, .rstn, .data_wr, .data_wdata,
   .rx_data_r, .ctrl_wr, .ctrl_wdata, .ctrl_rdata, .rx_pin, .port_tx_value, .tx_pin,
   .rx_port_value, .tx_output_select, .tx_irq, .rx_irq);

// *** hdasp_peer.sv ***
// Remote serial peer: sends characters on rx_pin, decodes tx_pin.
// Assumes the device bit time is BIT cycles of clk_sys.
`timescale 1ns/100ps
module hdasp_peer #(
   parameter int BIT = 208
) (
   input  wire logic clk_sys,
   input  wire logic tx_pin,
   input  wire logic tx_output_select,
   output logic      rx_pin
);
   logic [10:0] frame = 11'h000;
   int          cnt = 0;
   initial rx_pin = 1'b1;
   // Decode near mid-bit; first bit may be a tick short
   initial forever begin
      @(posedge tx_output_select);
      repeat (BIT * 7 / 16) @(posedge clk_sys);
      for (int i = 0; i < 11; i++) begin
         #1 frame[i] = ~tx_pin;
         if (i < 10) repeat (BIT) @(posedge clk_sys);
      end
      cnt++;
   end
   // Optional short pulse in the first data bit
   task automatic send(input logic [8:0] d, input logic g);
      logic [10:0] f;
      f = {1'b1, d, 1'b0};
      for (int i = 0; i < 11; i++) begin
         @(posedge clk_sys) #1;
         rx_pin = f[i];
         if (g && i == 1) begin
            repeat (100) @(posedge clk_sys);
            #1 rx_pin = ~f[i];
            repeat (20) @(posedge clk_sys);
            #1 rx_pin = f[i];
            repeat (BIT - 121) @(posedge clk_sys);
         end else
            repeat (BIT - 1) @(posedge clk_sys);
      end
   endtask
endmodule

// *** tb_top.sv ***
// Testbench for the half-duplex serial port.
// Assumes baud code 6 (208 cycles per bit) and the peer model.
`timescale 1ns/100ps
module tb_top;
   logic       clk_sys = 1'b0;
   logic       rstn = 1'b0;
   logic       data_wr = 1'b0;
   logic       ctrl_wr = 1'b0;
   logic       port_tx_value = 1'b1;
   logic [7:0] data_wdata = 8'h00;
   logic [7:0] ctrl_wdata = 8'h00;
   logic [7:0] d;
   wire  [7:0] rx_data_r, ctrl_rdata;
   wire        rx_pin, tx_pin, rx_port_value, tx_output_select, tx_irq, rx_irq;
   int         failures = 0;
   int         compares = 0;
   int         cyc = 0;
   int         n;
   hdasp_top u_hdasp_top (.clk_sys, .rstn, .data_wr, .data_wdata, .rx_data_r, .ctrl_wr,
      .ctrl_wdata, .ctrl_rdata, .rx_pin, .port_tx_value, .tx_pin, .rx_port_value,
      .tx_output_select, .tx_irq, .rx_irq);
   hdasp_peer #(.BIT(208)) peer (.clk_sys, .tx_pin, .tx_output_select, .rx_pin);
   initial forever #5 clk_sys = ~clk_sys;
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic cw(input logic [7:0] v);
      @(posedge clk_sys) #1;
      ctrl_wr = 1'b1;
      ctrl_wdata = v;
      @(posedge clk_sys) #1;
      ctrl_wr = 1'b0;
   endtask
   task automatic dw(input logic [7:0] v);
      @(posedge clk_sys) #1;
      data_wr = 1'b1;
      data_wdata = v;
      @(posedge clk_sys) #1;
      data_wr = 1'b0;
   endtask
   task automatic finish_test;
      $display("failures %0d compares %0d", failures, compares);
      if (failures == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         failures++;
         finish_test;
      end
   end
   initial begin
      repeat (8) @(posedge clk_sys);
      #1 rstn = 1'b1;
      repeat (3) @(posedge clk_sys);
      chk("ctrl", ctrl_rdata, 8'h00);
      chk("sel", tx_output_select, 1'b0);
      chk("pin", tx_pin, 1'b1);
      // Baud and ninth bit set before sending
      cw(8'h1d);
      chk("ctrl", ctrl_rdata, 8'h1d);
      for (int k = 0; k < 2; k++) begin
         d = k ? 8'h3c : 8'ha5;
         n = peer.cnt;
         dw(d);
         chk("empty", ctrl_rdata[6], 1'b0);
         for (int i = 0; i < 3000 && peer.cnt == n; i++) @(posedge clk_sys);
         chk("frame", peer.frame, {2'b11, d, 1'b0});
         for (int i = 0; i < 300 && tx_output_select; i++) @(posedge clk_sys) #1;
         chk("empty", ctrl_rdata[6], 1'b1);
         chk("txirq", tx_irq, 1'b1);
      end
      cw(8'h0d);
      chk("ctrl", ctrl_rdata, 8'h0d);
      chk("txirq", tx_irq, 1'b0);
      cw(8'h5d);
      chk("txirq", tx_irq, 1'b1);
      cw(8'h2d);
      peer.send(9'h05a, 1'b1);
      for (int i = 0; i < 400 && !ctrl_rdata[7]; i++) @(posedge clk_sys) #1;
      chk("rxdata", rx_data_r, 8'h5a);
      chk("ninth", ctrl_rdata[0], 1'b0);
      chk("rxirq", rx_irq, 1'b1);
      cw(8'h2c);
      peer.send(9'h1c3, 1'b0);
      for (int i = 0; i < 400 && !ctrl_rdata[7]; i++) @(posedge clk_sys) #1;
      chk("rxdata", rx_data_r, 8'hc3);
      chk("ninth", ctrl_rdata[0], 1'b1);
      // Transmit started mid-reception wins
      cw(8'h0c);
      fork
         peer.send(9'h0ff, 1'b0);
         begin
            repeat (600) @(posedge clk_sys);
            n = peer.cnt;
            dw(8'h81);
            for (int i = 0; i < 3000 && peer.cnt == n; i++) @(posedge clk_sys);
            chk("frame", peer.frame, {2'b10, 8'h81, 1'b0});
         end
      join
      for (int i = 0; i < 300 && tx_output_select; i++) @(posedge clk_sys) #1;
      chk("rx_ready_flag", ctrl_rdata[7], 1'b0);
      finish_test;
   end
endmodule
